// *** src/quarter_tick.sv ***
// Quarter-bit tick generator for the serial engine.
// Assumes period is stable while run is high.
`timescale 1ns/1ps
module quarter_tick #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  // Tick out
  output logic              tick
);

  logic [W-1:0] count;

  // Tick once every period+1 cycles; restart when halted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!run || count == period) begin
      count <= '0;
      tick  <= run;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule : quarter_tick

// *** src/two_wire_master_receiver.sv ***
// Two-wire serial master receiver with an AHB-Lite register port.
// Assumes synchronous scl_in/sda_in and an external open-drain pad.
`timescale 1ns/1ps
module two_wire_master_receiver (
  // Clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [two_wire_pkg::AW-1:0] haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [two_wire_pkg::DW-1:0] hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [two_wire_pkg::DW-1:0] hrdata,
  // Serial clock pin
  input  wire logic                        scl_in,
  output logic                             scl_out,
  output logic                             scl_oe,
  // Serial data pin
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe
);
  import two_wire_pkg::*;

  // Software-visible registers
  logic       flag;
  logic       ack_enable;
  logic       start_request;
  logic       stop_request;
  logic       write_collision_flag;
  logic       interface_enable;
  logic       event_interrupt_enable;
  logic [7:0] code;
  logic [1:0] presc;
  logic [7:0] bus_data;
  logic [7:0] rate;

  // Bus slave state
  logic       wr_pend;
  logic       rd_pend;
  logic [7:0] acc_addr;

  // Serial engine state
  link_state_t state;
  logic [1:0]  phase;
  logic [2:0]  bitn;
  logic [7:0]  shreg;
  logic        dir_read;
  logic        repeated;
  logic        smp;
  logic        ev;
  logic [7:0]  ev_code;
  logic        rx_done;
  logic        stop_done;

  // Bus monitor
  logic scl_q;
  logic sda_q;
  logic busy;

  // Register decode; hsize is ignored since only word accesses occur
  wire        addr_ok  = hsel & htrans[1] & hready;
  wire        ctrl_wr  = wr_pend & (acc_addr == OFF_CONTROL);
  wire        stat_wr  = wr_pend & (acc_addr == OFF_STATUS);
  wire        data_wr  = wr_pend & (acc_addr == OFF_DATA);
  wire        rate_wr  = wr_pend & (acc_addr == OFF_RATE);
  wire        flag_clr = ctrl_wr & hwdata[B_FLAG];
  wire [7:0]  ctrl_rd  = {flag, ack_enable, start_request, stop_request,
                          write_collision_flag, interface_enable, 1'b0,
                          event_interrupt_enable};
  wire [7:0]  stat_rd  = {code[7:CODE_LSB], 1'b0, presc};
  wire [7:0]  rd_mux   = (acc_addr == OFF_CONTROL) ? ctrl_rd  :
                         (acc_addr == OFF_STATUS)  ? stat_rd  :
                         (acc_addr == OFF_DATA)    ? bus_data :
                         (acc_addr == OFF_RATE)    ? rate     : 8'h00;

  // Bus monitor decode: start and stop seen by sampling both lines
  wire bus_start = scl_in & scl_q & sda_q & ~sda_in;
  wire bus_stop  = scl_in & scl_q & ~sda_q & sda_in;

  // Serial engine decode
  wire tick;
  wire in_bit   = (state != S_IDLE) && (state != S_HOLD);
  wire adv      = tick & in_bit & ((phase != 2'd2) | scl_in);  // Waits out clock stretch
  wire want_low = (state == S_START) | (state == S_STOP) |
                  ((state == S_ADDR) & ~shreg[7]) |
                  ((state == S_MACK) & ack_enable);
  wire lost     = ~sda_oe & ~sda_in & ((state == S_ADDR) | (state == S_MACK));
  wire go_start = interface_enable & start_request & ~flag & ~busy;

  quarter_tick #(
    .W (8)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (in_bit),
    .period  (rate),
    .tick    (tick)
  );

  // AHB-Lite slave: writes commit in the data phase, reads add one wait
  // state so a read right after a write sees the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      acc_addr  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ok & hwrite;
      rd_pend <= addr_ok & ~hwrite;
      hresp   <= 1'b0;                  // Always OKAY, unmapped reads give zero
      if (addr_ok) begin
        acc_addr <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
      end
      if (addr_ok & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        hreadyout <= 1'b1;
        hrdata    <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= CONTROL_RST[B_FLAG];
      code <= SC_IDLE;
    end else begin
      if (ev) begin
        flag <= 1'b1;
        code <= ev_code;
      end else begin
        if (flag_clr) flag <= 1'b0;
        if (stop_done) code <= SC_IDLE;
      end
    end
  end

  // Control bits, prescaler, bit rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_enable             <= CONTROL_RST[B_ACK];
      start_request          <= CONTROL_RST[B_STA];
      stop_request           <= CONTROL_RST[B_STO];
      interface_enable       <= CONTROL_RST[B_EN];
      event_interrupt_enable <= CONTROL_RST[B_IE];
      presc                  <= PRESC_RST;
      rate                   <= RATE_RST;
    end else begin
      if (ctrl_wr) begin
        ack_enable             <= hwdata[B_ACK];
        start_request          <= hwdata[B_STA];
        stop_request           <= hwdata[B_STO];
        interface_enable       <= hwdata[B_EN];
        event_interrupt_enable <= hwdata[B_IE];
      end else if (stop_done) begin
        stop_request <= 1'b0;
      end
      if (stat_wr) presc <= hwdata[1:0];
      if (rate_wr) rate <= hwdata[7:0];
    end
  end

  // Data register: software writes load only while the flag is set, else a collision; received bytes always load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_data             <= DATA_RST;
      write_collision_flag <= CONTROL_RST[B_WC];
    end else begin
      if (rx_done) begin
        bus_data <= shreg;
      end else if (data_wr & flag) begin
        bus_data <= hwdata[7:0];
      end
      if (data_wr) write_collision_flag <= ~flag;
    end
  end

  // Bus monitor: another master's start marks the bus busy until stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy  <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (!interface_enable | bus_stop) begin
        busy <= 1'b0;
      end else if (bus_start) begin
        busy <= 1'b1;
      end
    end
  end

  // Serial engine. Each bit runs four quarter ticks: set data, release
  // clock, sample once the clock is high, pull clock low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= S_IDLE;
      phase     <= 2'd0;
      bitn      <= 3'd7;
      shreg     <= 8'h00;
      dir_read  <= 1'b0;
      repeated  <= 1'b0;
      smp       <= 1'b1;
      ev        <= 1'b0;
      ev_code   <= SC_IDLE;
      rx_done   <= 1'b0;
      stop_done <= 1'b0;
      scl_out   <= 1'b0;
      scl_oe    <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      ev        <= 1'b0;
      rx_done   <= 1'b0;
      stop_done <= 1'b0;
      scl_out   <= 1'b0;
      sda_out   <= 1'b0;
      if (!interface_enable) begin
        state    <= S_IDLE;
        phase    <= 2'd0;
        repeated <= 1'b0;
        scl_oe   <= 1'b0;
        sda_oe   <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            if (go_start) begin
              state <= S_START;
              phase <= 2'd0;
            end
          end
          S_HOLD: begin
            // Clock stays low from the last bit until the flag clears, except after lost arbitration, which releases it
            if (!flag && !ev) begin
              phase <= 2'd0;
              bitn  <= 3'd7;
              case (code)
                SC_START, SC_RESTART: begin
                  shreg    <= bus_data;
                  dir_read <= bus_data[0];
                  state    <= S_ADDR;
                end
                SC_RADDR_AK, SC_RX_AK: begin
                  state <= S_RX;
                end
                SC_ARB_LOST: begin
                  state    <= S_IDLE;
                  repeated <= 1'b0;
                end
                default: begin
                  // Stop first when both are set, start follows from idle
                  if (stop_request) begin
                    state <= S_STOP;
                  end else if (start_request) begin
                    state <= S_RSTART;
                  end
                end
              endcase
            end
          end
          default: begin
            if (adv) begin
              phase <= phase + 2'd1;
              case (phase)
                2'd0: begin
                  sda_oe <= want_low;
                end
                2'd1: begin
                  scl_oe <= 1'b0;
                end
                2'd2: begin
                  smp <= sda_in;
                  if (state == S_RX) shreg <= {shreg[6:0], sda_in};
                  if (lost) begin
                    // Another master won; let go of both lines at once
                    scl_oe  <= 1'b0;
                    sda_oe  <= 1'b0;
                    state   <= S_HOLD;
                    phase   <= 2'd0;
                    ev      <= 1'b1;
                    ev_code <= SC_ARB_LOST;
                  end
                end
                default: begin
                  if (state != S_RSTART && state != S_STOP) scl_oe <= 1'b1;
                  case (state)
                    S_START: begin
                      state    <= S_HOLD;
                      ev       <= 1'b1;
                      ev_code  <= repeated ? SC_RESTART : SC_START;
                      repeated <= 1'b1;
                    end
                    S_RSTART: begin
                      state <= S_START;
                    end
                    S_STOP: begin
                      sda_oe    <= 1'b0;
                      stop_done <= 1'b1;
                      repeated  <= 1'b0;
                      state     <= S_IDLE;
                    end
                    S_ADDR: begin
                      shreg <= {shreg[6:0], 1'b0};
                      bitn  <= bitn - 3'd1;
                      if (bitn == 3'd0) state <= S_AACK;
                    end
                    S_AACK: begin
                      state   <= S_HOLD;
                      ev      <= 1'b1;
                      ev_code <= dir_read ? (smp ? SC_RADDR_NK : SC_RADDR_AK)
                                          : (smp ? SC_WADDR_NK : SC_WADDR_AK);
                    end
                    S_RX: begin
                      bitn <= bitn - 3'd1;
                      if (bitn == 3'd0) state <= S_MACK;
                    end
                    S_MACK: begin
                      sda_oe  <= 1'b0;
                      rx_done <= 1'b1;
                      state   <= S_HOLD;
                      ev      <= 1'b1;
                      ev_code <= sda_oe ? SC_RX_AK : SC_RX_NK;
                    end
                    default: begin
                      state <= S_IDLE;
                    end
                  endcase
                end
              endcase
            end
          end
        endcase
      end
    end
  end

endmodule : two_wire_master_receiver

// *** src/two_wire_pkg.sv ***
// Shared constants for the two-wire master receiver block.
// Assumes a 100 MHz system clock and a single AHB-Lite slave port.
package two_wire_pkg;

  // Bus widths
  localparam int AW = 32;
  localparam int DW = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_DATA    = 8'h08;
  localparam logic [7:0] OFF_RATE    = 8'h0C;

  // Control register bit positions
  localparam int B_FLAG = 7;
  localparam int B_ACK  = 6;
  localparam int B_STA  = 5;
  localparam int B_STO  = 4;
  localparam int B_WC   = 3;
  localparam int B_EN   = 2;
  localparam int B_IE   = 0;

  // Status register layout: code in [7:3], prescaler in [1:0]
  localparam int CODE_LSB = 3;

  // Status codes with prescaler bits at zero
  localparam logic [7:0] SC_START    = 8'h08;
  localparam logic [7:0] SC_RESTART  = 8'h10;
  localparam logic [7:0] SC_WADDR_AK = 8'h18;
  localparam logic [7:0] SC_WADDR_NK = 8'h20;
  localparam logic [7:0] SC_ARB_LOST = 8'h38;
  localparam logic [7:0] SC_RADDR_AK = 8'h40;
  localparam logic [7:0] SC_RADDR_NK = 8'h48;
  localparam logic [7:0] SC_RX_AK    = 8'h50;
  localparam logic [7:0] SC_RX_NK    = 8'h58;
  localparam logic [7:0] SC_IDLE     = 8'hF8;

  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'hFF;
  localparam logic [1:0] PRESC_RST   = 2'h0;

  // Timing: default serial bit time, quarter-bit tick in clock cycles
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BIT_TIME_NS    = 10000;
  localparam int QUARTER_CYCLES = BIT_TIME_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] RATE_RST = 8'(QUARTER_CYCLES - 1);

  // Serial engine states
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_START  = 4'h1,
    S_RSTART = 4'h2,
    S_ADDR   = 4'h3,
    S_AACK   = 4'h4,
    S_RX     = 4'h5,
    S_MACK   = 4'h6,
    S_STOP   = 4'h7,
    S_HOLD   = 4'h8
  } link_state_t;

endpackage : two_wire_pkg

// *** verification/slave_tx_model.sv ***
// Behavioural two-wire slave that sends a byte count on reads.
// Assumes resolved open-drain lines with pull-ups in the bench.
`timescale 1ns/1ps
module slave_tx #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Resolved lines and stretch enable
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  // Open-drain pulls
  output logic      scl_low,
  output logic      sda_low
);
  logic       act;
  logic       first;
  logic       rd;
  logic [7:0] sh;
  logic [7:0] tx;
  int         i;
  initial begin
    {act, scl_low, sda_low} = 3'h0;
    tx = 8'hA5;
  end
  // Start restarts the frame, stop drops off the bus
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    first = 1'b1;
    i = 0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sda_low = 1'b0;
  end
  // Sample address bits and the master's answer
  always @(posedge scl) if (act) begin
    if (first && i < 8) sh = {sh[6:0], sda};
    if (!first && rd && i == 8) begin
      if (sda) act = 1'b0;
      else tx = tx + 8'h01;
    end
    if (i == 8) first = 1'b0;
    i = (i == 8) ? 0 : i + 1;
  end
  // Drive only while scl is low; stretching holds it low for a while
  always @(negedge scl) if (act) begin
    if (first && i == 8) begin
      rd = sh[0];
      sda_low = (sh[7:1] == ADDR);
      act = sda_low;
    end else sda_low = !first && rd && i < 8 && !tx[7 - i];
    if (slow) begin
      scl_low = 1'b1;
      #300 scl_low = 1'b0;
    end
  end
endmodule : slave_tx

// *** verification/testbench.sv ***
// Self-checking bench for the two-wire master receiver.
// Assumes the slave model on the lines and hready tied to hreadyout.
`timescale 1ns/1ps
module testbench;
  import two_wire_pkg::*;
  localparam logic [7:0] RD_ADR = 8'h55;
  localparam logic [7:0] WR_ADR = 8'h54;
  localparam logic [7:0] NO_ADR = 8'h27;
  localparam int         LIMIT  = 40000;
  logic        hclk, hresetn, hsel, hwrite, bully, slow;
  logic        hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe;
  logic        scl_low, sda_low;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          error_cnt, total_checks, cyc;
  wire         hready = hreadyout;
  // Pull-ups win unless some party pulls low
  wire         scl_w = !scl_oe && !scl_low;
  wire         sda_w = !sda_oe && !sda_low && !bully;
  `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
  two_wire_master_receiver dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .scl_in(scl_w), .scl_out, .scl_oe,
    .sda_in(sda_w), .sda_out, .sda_oe
  );
  slave_tx slave (.scl(scl_w), .sda(sda_w), .slow, .scl_low, .sda_low);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Cut a hang short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // One single AHB transfer; address held until hready, then data phase
  // No wait limit of its own: only the cycle ceiling ends a hung transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    `CHK(nm, {24'h0, e}, q & {24'hFFFFFF, m})
  endtask : rdc
  // Bounded polling, since the serial pace is not fixed
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 8'h00, q);
      n++;
    end while ((q[7:0] & m) !== v && n < 3000);
    `CHK("poll", v, q[7:0] & m)
  endtask : poll
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    wr(OFF_CONTROL, c);
    poll(OFF_CONTROL, 8'h80, 8'h80);
    rdc("status", OFF_STATUS, 8'hF8, st);
  endtask : step
  task automatic stop;
    wr(OFF_CONTROL, 8'h94);
    poll(OFF_STATUS, 8'hF8, SC_IDLE);
    rdc("stop bit", OFF_CONTROL, 8'h10, 8'h00);
  endtask : stop
  initial begin
    {hsel, hwrite, bully, slow, hresetn} = 5'h0;
    {htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("control", OFF_CONTROL, 8'hFF, CONTROL_RST);
    rdc("status", OFF_STATUS, 8'hFF, SC_IDLE);
    rdc("data", OFF_DATA, 8'hFF, DATA_RST);
    rdc("rate", OFF_RATE, 8'hFF, RATE_RST);
    wr(8'h10, 8'h5A);
    rdc("unmapped", 8'h10, 8'hFF, 8'h00);
    // Ack and interrupt enable bits are stored while the interface is off
    wr(OFF_CONTROL, 8'h41);
    rdc("control rw", OFF_CONTROL, 8'hFF, 8'h41);
    wr(OFF_DATA, 8'h5A);
    rdc("collision", OFF_CONTROL, 8'h08, 8'h08);
    rdc("data kept", OFF_DATA, 8'hFF, DATA_RST);
    wr(OFF_RATE, 8'h03);
    rdc("rate rw", OFF_RATE, 8'hFF, 8'h03);
    wr(OFF_STATUS, 8'h03);
    rdc("prescaler", OFF_STATUS, 8'h03, 8'h03);
    $display("test registers done");
    // Start asked for while disabled must do nothing
    wr(OFF_CONTROL, 8'hA0);
    repeat (300) @(posedge hclk);
    rdc("disabled", OFF_STATUS, 8'hF8, SC_IDLE);
    `CHK("pins off", 2'b00, {scl_oe, sda_oe})
    // Another master's start marks the bus busy; ours must wait for its stop
    wr(OFF_CONTROL, 8'h04);
    bully <= 1'b1;
    wr(OFF_CONTROL, 8'hA4);
    repeat (200) @(posedge hclk);
    rdc("bus busy", OFF_CONTROL, 8'h80, 8'h00);
    `CHK("wait free", 2'b00, {scl_oe, sda_oe})
    bully <= 1'b0;
    poll(OFF_CONTROL, 8'h80, 8'h80);
    rdc("status", OFF_STATUS, 8'hF8, SC_START);
    `CHK("scl held", 1'b1, scl_oe)
    wr(OFF_DATA, RD_ADR);
    rdc("collision", OFF_CONTROL, 8'h08, 8'h00);
    bully <= 1'b1;
    step(8'h84, SC_ARB_LOST);
    `CHK("released", 2'b00, {scl_oe, sda_oe})
    bully <= 1'b0;
    step(8'hA4, SC_START);
    $display("test arbitration done");
    // Two bytes, ACK then NACK, then turn round to a write address
    wr(OFF_DATA, RD_ADR);
    step(8'hC4, SC_RADDR_AK);
    step(8'hC4, SC_RX_AK);
    rdc("byte", OFF_DATA, 8'hFF, 8'hA5);
    step(8'h84, SC_RX_NK);
    rdc("byte", OFF_DATA, 8'hFF, 8'hA6);
    step(8'hA4, SC_RESTART);
    wr(OFF_DATA, WR_ADR);
    step(8'h84, SC_WADDR_AK);
    stop();
    $display("test read done");
    // Refused address, stop with start, restart, slow slave
    step(8'hA4, SC_START);
    wr(OFF_DATA, NO_ADR);
    step(8'h84, SC_RADDR_NK);
    step(8'hB4, SC_START);
    rdc("stop bit", OFF_CONTROL, 8'h10, 8'h00);
    wr(OFF_DATA, NO_ADR);
    step(8'h84, SC_RADDR_NK);
    step(8'hA4, SC_RESTART);
    slow <= 1'b1;
    wr(OFF_DATA, RD_ADR);
    step(8'h84, SC_RADDR_AK);
    step(8'h84, SC_RX_NK);
    rdc("byte", OFF_DATA, 8'hFF, 8'hA6);
    stop();
    $display("test refused done");
    summarize();
  end
endmodule : testbench

// *** verification/two_wire_props.sv ***
// Assertions on the register port and pins of the master receiver.
// Assumes hready is tied to hreadyout; bound to the top module.
`timescale 1ns/1ps
module two_wire_props (
  // Clock and reset
  input wire logic                        hclk,
  input wire logic                        hresetn,
  // Register port
  input wire logic                        hsel,
  input wire logic [two_wire_pkg::AW-1:0] haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [two_wire_pkg::DW-1:0] hwdata,
  input wire logic                        hready,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic [two_wire_pkg::DW-1:0] hrdata,
  // Pins
  input wire logic                        scl_in,
  input wire logic                        scl_out,
  input wire logic                        scl_oe,
  input wire logic                        sda_out,
  input wire logic                        sda_oe
);
  import two_wire_pkg::*;
  logic       wr_ph;
  logic       en_q;
  logic [7:0] ph_a;
  wire        req = hsel && htrans[1] && hready;
  // Follow the enable bit through control writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      ph_a  <= 8'h00;
      en_q  <= 1'b0;
    end else if (hready) begin
      wr_ph <= req && hwrite;
      ph_a  <= haddr[7:0];
      if (wr_ph && ph_a == OFF_CONTROL) en_q <= hwdata[B_EN];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_od;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_rwait;
    req && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rwait: assert property (p_rwait) else $error("read wait wrong");
  property p_wfast;
    req && hwrite |=> hreadyout;
  endproperty
  a_wfast: assert property (p_wfast) else $error("write stalled");
  property p_upper;
    req && !hwrite |-> ##2 hrdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmap;
    req && !hwrite && haddr[7:0] > OFF_RATE |-> ##2 hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_idle;
    (!en_q)[*8] |-> !scl_oe && !sda_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("lines pulled while off");
  property p_start;
    $rose(sda_oe) && scl_in && !scl_oe |-> ##[1:1000] scl_oe;
  endproperty
  a_start: assert property (p_start) else $error("clock not held");
endmodule : two_wire_props

bind two_wire_master_receiver two_wire_props u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe
);
